// ===== src/mps_sequencer.sv
// Purpose: Stages and destages a booster pump set around one variable speed drive.
// Assumes: Ready inputs are asynchronous pins; commands drive contactor relays.
// Notes:   Control bits live in REG_CTRL; all timing counts are in seconds.
// Operation
// - One variable pump plus five auxiliaries.
// - Pump total from pump count setting.
// - No alternation keeps lead tied permanently.
// - Multi drives forbids alternation, uses device count.
// - FIFO starts and stops ascending.
// - LIFO starts ascending, stops descending.
// - Runtime mode uses least/most runtime.
// - Lead starts first, stops last.
// - No alternation makes pump one lead.
// - Stage alternation moves lead each stage.
// - New staged pump becomes lead.
// - Wait time on every staging lead switch.
// - Destage fixed pumps by cycling mode.
// - Ready delay holds stopped pump unavailable; the code holds only a pump stopped by a destage request.
// - Period elapsing forces an alternation.
// - Expose state, available and staged counts.
// - Expose lead, next stage, next destage.
// - Per pump state, type, runtime, starts.
// - Flag flying restart on lead reuse.
// - Unassigned ready input means always available.
// - Capacity warning when demand exceeds availability.
// - Lead error when running lead lost.
//
// Our own choices: the register offsets and strobed register access.
module mps_sequencer #(
  parameter int unsigned NP          = mps_pkg::MAX_PUMPS,
  parameter int unsigned TICK_CYCLES = mps_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // Register port
  input  wire logic [mps_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // Pump side
  input  wire logic [NP-1:0]               pump_ready,
  input  wire logic [NP-1:0]               ready_assigned,
  output logic      [NP-1:0]               pump_cmd,
  output logic                             drive_run,
  output logic                             flying_restart,
  output logic                             capacity_warn,
  output logic                             lead_error
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

  mps_pkg::mps_bus_type bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Synchronisers: a change counts once stages two and three agree.
  logic [NP-1:0] rdy_s1_r, rdy_s2_r, rdy_s3_r, rdy_f_r, rdy_f_nxt;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdy_s1_r <= '0;
      rdy_s2_r <= '0;
      rdy_s3_r <= '0;
      rdy_f_r  <= '0;
    end else begin
      rdy_s1_r <= pump_ready;
      rdy_s2_r <= rdy_s1_r;
      rdy_s3_r <= rdy_s2_r;
      rdy_f_r  <= rdy_f_nxt;
    end
  end
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      rdy_f_nxt[i] = (rdy_s2_r[i] == rdy_s3_r[i]) ? rdy_s3_r[i] : rdy_f_r[i];
    end
  end

  // Configuration registers.
  logic [31:0] ctrl_r, ctrl_nxt, wait_r, wait_nxt, rdly_r, rdly_nxt, per_r, per_nxt;
  mps_pkg::mps_arch_type arch;
  mps_pkg::mps_cyc_type  cyc;
  logic [2:0] cnt_cfg, dev_cfg, npumps;
  logic       alt_en, run_cmd, stage_req, dest_req;
  always_comb begin
    ctrl_nxt = ctrl_r;
    wait_nxt = wait_r;
    rdly_nxt = rdly_r;
    per_nxt  = per_r;
    if (bus.wr) begin
      case (bus.addr)
        mps_pkg::REG_CTRL:      ctrl_nxt = bus.wdata;
        mps_pkg::REG_WAIT:      wait_nxt = bus.wdata;
        mps_pkg::REG_READY_DLY: rdly_nxt = bus.wdata;
        mps_pkg::REG_PERIOD:    per_nxt  = bus.wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= mps_pkg::CTRL_RESET;
      wait_r <= 32'h0000_0000;
      rdly_r <= 32'h0000_0000;
      per_r  <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      wait_r <= wait_nxt;
      rdly_r <= rdly_nxt;
      per_r  <= per_nxt;
    end
  end
  assign arch      = mps_pkg::mps_arch_type'(ctrl_r[mps_pkg::CTRL_ARCH_LSB +: 2]);
  assign cyc       = mps_pkg::mps_cyc_type'(ctrl_r[mps_pkg::CTRL_CYC_LSB +: 2]);
  assign cnt_cfg   = ctrl_r[mps_pkg::CTRL_CNT_LSB +: 3];
  assign dev_cfg   = ctrl_r[mps_pkg::CTRL_DEV_LSB +: 3];
  assign run_cmd   = ctrl_r[mps_pkg::CTRL_RUN_BIT];
  assign stage_req = bus.wr && bus.addr == mps_pkg::REG_CTRL && bus.wdata[mps_pkg::CTRL_STAGE_BIT];
  assign dest_req  = bus.wr && bus.addr == mps_pkg::REG_CTRL && bus.wdata[mps_pkg::CTRL_DEST_BIT];
  assign alt_en = ctrl_r[mps_pkg::CTRL_ALT_BIT] && arch == mps_pkg::MPS_ARCH_SINGLE;
  always_comb begin
    case (arch)
      mps_pkg::MPS_ARCH_SINGLE: npumps = cnt_cfg;
      mps_pkg::MPS_ARCH_MULTI:  npumps = dev_cfg;
      default:                  npumps = 3'h1;
    endcase
    if (npumps > 3'(mps_pkg::MAX_AUX + 1)) npumps = 3'(mps_pkg::MAX_AUX + 1);
    if (npumps == 3'h0) npumps = 3'h1;
  end

  // Second tick and per-pump counters.
  logic [CW-1:0] pre_r, pre_nxt;
  logic          tick;
  logic [31:0]   rt_r [NP], rt_nxt [NP];
  logic [15:0]   st_r [NP], st_nxt [NP];
  logic [31:0]   hold_r [NP], hold_nxt [NP];
  logic [NP-1:0] cmd_r, cmd_nxt, avail, in_use;
  logic [2:0]    lead_r, lead_nxt, nst, nde;
  logic [31:0]   wcnt_r, wcnt_nxt, pcnt_r, pcnt_nxt;
  logic          fly_r, fly_nxt, err_r, err_nxt;
  mps_pkg::mps_state_type state_r, state_nxt;
  assign tick = (pre_r == CW'(TICK_CYCLES - 1));

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      in_use[i] = (i < int'(npumps));
      avail[i]  = in_use[i] && (!ready_assigned[i] || rdy_f_r[i]) && hold_r[i] == 32'h0;
    end
  end

  function automatic logic [2:0] popcnt(input logic [NP-1:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < NP; i++) c = c + 3'(v[i]);
    return c;
  endfunction : popcnt

  always_comb begin
    logic [31:0] best;
    best = 32'hFFFF_FFFF;
    nst  = 3'h7;
    nde  = 3'h7;
    for (int i = NP - 1; i >= 0; i--) begin
      if (avail[i] && !cmd_r[i] && (alt_en || i != 0)) begin
        if (cyc != mps_pkg::MPS_CYC_RUNTIME || rt_r[i] <= best) begin
          nst  = 3'(i);
          best = rt_r[i];
        end
      end
    end
    best = 32'h0;
    for (int i = 0; i < NP; i++) begin
      if (cmd_r[i] && 3'(i) != lead_r) begin
        case (cyc)
          mps_pkg::MPS_CYC_FIFO: if (nde == 3'h7) nde = 3'(i);
          mps_pkg::MPS_CYC_LIFO: nde = 3'(i);
          mps_pkg::MPS_CYC_RUNTIME: if (nde == 3'h7 || rt_r[i] > best) begin
            nde  = 3'(i);
            best = rt_r[i];
          end
          default: ;
        endcase
      end
    end
    if (nde == 3'h7 && cmd_r[lead_r]) nde = lead_r;
  end

  // Sequencing state.
  always_comb begin
    pre_nxt   = tick ? '0 : pre_r + CW'(1);
    cmd_nxt   = cmd_r;
    lead_nxt  = lead_r;
    state_nxt = state_r;
    wcnt_nxt  = wcnt_r;
    pcnt_nxt  = pcnt_r;
    fly_nxt   = 1'b0;
    err_nxt   = err_r;
    for (int i = 0; i < NP; i++) begin
      rt_nxt[i]   = (tick && cmd_r[i]) ? rt_r[i] + 32'h1 : rt_r[i];
      st_nxt[i]   = st_r[i];
      hold_nxt[i] = (tick && hold_r[i] != 32'h0) ? hold_r[i] - 32'h1 : hold_r[i];
    end
    for (int i = 0; i < NP; i++) begin
      if (cmd_r[i] && !avail[i] && 3'(i) != lead_r) cmd_nxt[i] = 1'b0;
    end
    pcnt_nxt = (cmd_r != '0 && tick && per_r != 32'h0) ? pcnt_r + 32'h1 : pcnt_r;
    case (state_r)
      mps_pkg::MPS_ST_IDLE: begin
        if (!alt_en) lead_nxt = 3'h0;
        else if (nst != 3'h7) lead_nxt = nst;
        if (run_cmd && avail[lead_nxt]) begin
          cmd_nxt[lead_nxt] = 1'b1;
          st_nxt[lead_nxt]  = st_r[lead_nxt] + 16'h1;
          state_nxt         = mps_pkg::MPS_ST_RUN;
        end
      end
      mps_pkg::MPS_ST_RUN: begin
        if (!run_cmd) begin
          cmd_nxt   = '0;
          state_nxt = mps_pkg::MPS_ST_IDLE;
        end else if (!avail[lead_r]) begin
          cmd_nxt   = '0;
          err_nxt   = 1'b1;
          state_nxt = mps_pkg::MPS_ST_ERROR;
        end else if (stage_req && nst != 3'h7) begin
          cmd_nxt[nst] = 1'b1;
          st_nxt[nst]  = st_r[nst] + 16'h1;
          if (alt_en) begin
            lead_nxt  = nst;
            cmd_nxt[nst] = 1'b0;
            fly_nxt   = 1'b1;
            wcnt_nxt  = wait_r;
            state_nxt = mps_pkg::MPS_ST_WAIT;
          end
        end else if (dest_req && nde != 3'h7 && nde != lead_r) begin
          cmd_nxt[nde]  = 1'b0;
          hold_nxt[nde] = rdly_r;
        end else if (alt_en && per_r != 32'h0 && pcnt_r >= per_r) begin
          pcnt_nxt  = 32'h0;
          cmd_nxt   = '0;
          state_nxt = mps_pkg::MPS_ST_IDLE;
        end
      end
      mps_pkg::MPS_ST_WAIT: begin
        if (tick && wcnt_r != 32'h0) wcnt_nxt = wcnt_r - 32'h1;
        if (!run_cmd) begin
          cmd_nxt   = '0;
          state_nxt = mps_pkg::MPS_ST_IDLE;
        end else if (wcnt_r == 32'h0 && avail[lead_r]) begin
          fly_nxt          = 1'b1;
          cmd_nxt[lead_r]  = 1'b1;
          st_nxt[lead_r]   = st_r[lead_r] + 16'h1;
          state_nxt        = mps_pkg::MPS_ST_RUN;
        end
      end
      mps_pkg::MPS_ST_ERROR: begin
        if (!run_cmd) begin
          err_nxt   = 1'b0;
          state_nxt = mps_pkg::MPS_ST_IDLE;
        end
      end
      default: state_nxt = mps_pkg::MPS_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pre_r   <= '0;
      cmd_r   <= '0;
      lead_r  <= 3'h0;
      state_r <= mps_pkg::MPS_ST_IDLE;
      wcnt_r  <= 32'h0;
      pcnt_r  <= 32'h0;
      fly_r   <= 1'b0;
      err_r   <= 1'b0;
      for (int i = 0; i < NP; i++) begin
        rt_r[i]   <= 32'h0;
        st_r[i]   <= 16'h0;
        hold_r[i] <= 32'h0;
      end
    end else begin
      pre_r   <= pre_nxt;
      cmd_r   <= cmd_nxt;
      lead_r  <= lead_nxt;
      state_r <= state_nxt;
      wcnt_r  <= wcnt_nxt;
      pcnt_r  <= pcnt_nxt;
      fly_r   <= fly_nxt;
      err_r   <= err_nxt;
      for (int i = 0; i < NP; i++) begin
        rt_r[i]   <= rt_nxt[i];
        st_r[i]   <= st_nxt[i];
        hold_r[i] <= hold_nxt[i];
      end
    end
  end

  assign pump_cmd       = cmd_r;
  assign drive_run      = state_r == mps_pkg::MPS_ST_RUN;
  assign flying_restart = fly_r;
  assign lead_error     = err_r;
  assign capacity_warn  = run_cmd && (popcnt(avail) == 3'h0 || (stage_req && nst == 3'h7));

  // Read port; data stands only in the cycle after the strobe.
  logic [31:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        mps_pkg::REG_CTRL:      rdata_nxt = ctrl_r;
        mps_pkg::REG_WAIT:      rdata_nxt = wait_r;
        mps_pkg::REG_READY_DLY: rdata_nxt = rdly_r;
        mps_pkg::REG_PERIOD:    rdata_nxt = per_r;
        mps_pkg::REG_STATUS:    rdata_nxt = {5'h0, nde, 1'b0, nst, 1'b0, lead_r,
                                             1'b0, popcnt(cmd_r), 1'b0, popcnt(avail), 6'h0, 2'(state_r)};
        default: begin
          for (int i = 0; i < NP; i++) begin
            if (bus.addr == mps_pkg::REG_PUMP_BASE + 8'(4 * i)) rdata_nxt = rt_r[i];
            if (bus.addr == mps_pkg::REG_START_BASE + 8'(4 * i))
              rdata_nxt = {12'h0, avail[i], cmd_r[i], 3'(i) == lead_r, 1'b0, st_r[i]};
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) rdata_r <= 32'h0;
    else rdata_r <= rdata_nxt;
  end
  assign reg_rdata = rdata_r;
endmodule : mps_sequencer

// ===== src/mps_pkg.sv
// Purpose: Shared constants and types for the pump staging sequencer.
// Assumes: 25 MHz system clock, up to six pumps.
// Notes:   Register offsets are byte addresses of 32-bit words.
package mps_pkg;
  localparam int unsigned MAX_PUMPS      = 6;
  localparam int unsigned MAX_AUX        = 5;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned CLK_HZ         = 25_000_000;
  // Seconds to cycles: one runtime tick per second.
  localparam int unsigned SEC_NS         = 1_000_000_000;
  localparam int unsigned CLK_NS         = SEC_NS / CLK_HZ;
  localparam int unsigned TICK_CYCLES    = SEC_NS / CLK_NS;

  // Register map.
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_WAIT        = 8'h04;
  localparam logic [7:0] REG_READY_DLY   = 8'h08;
  localparam logic [7:0] REG_PERIOD      = 8'h0C;
  localparam logic [7:0] REG_STATUS      = 8'h10;
  localparam logic [7:0] REG_PUMP_BASE   = 8'h20;
  localparam logic [7:0] REG_START_BASE  = 8'h40;

  // Control field positions.
  localparam int unsigned CTRL_ARCH_LSB  = 0;
  localparam int unsigned CTRL_CNT_LSB   = 4;
  localparam int unsigned CTRL_CYC_LSB   = 8;
  localparam int unsigned CTRL_ALT_BIT   = 12;
  localparam int unsigned CTRL_DEV_LSB   = 16;
  localparam int unsigned CTRL_RUN_BIT   = 20;
  localparam int unsigned CTRL_STAGE_BIT = 24;
  localparam int unsigned CTRL_DEST_BIT  = 25;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {
    MPS_ARCH_MONO   = 2'h0,
    MPS_ARCH_SINGLE = 2'h1,
    MPS_ARCH_MULTI  = 2'h2
  } mps_arch_type;

  typedef enum logic [1:0] {
    MPS_CYC_FIFO    = 2'h0,
    MPS_CYC_LIFO    = 2'h1,
    MPS_CYC_RUNTIME = 2'h2
  } mps_cyc_type;

  typedef enum logic [1:0] {
    MPS_ST_IDLE  = 2'h0,
    MPS_ST_RUN   = 2'h1,
    MPS_ST_WAIT  = 2'h3,
    MPS_ST_ERROR = 2'h2
  } mps_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } mps_bus_type;
endpackage : mps_pkg

// ===== test/mps_pump_model.sv
// Purpose: Pump set stand-in whose ready contacts follow an availability mask.
// Assumes: Ready contacts are plain driven levels with no pull network.
// Notes:   Contactors are ideal, so ready never depends on the relay command.
module mps_pump_model #(
  parameter int unsigned NP = 6
) (
  // Availability chosen by the bench
  input  wire logic [NP-1:0] avail,
  // Ready contacts
  output logic      [NP-1:0] pump_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pump_ready = avail;
endmodule : mps_pump_model

// ===== test/mps_sequencer_assertions.sv
// Purpose: Port-level checks for the pump staging sequencer.
// Assumes: Control word is mirrored from register writes, request bits masked.
// Notes:   Ready inputs cross a short synchroniser, so checks look a few cycles back.
module mps_sequencer_assertions #(
  parameter int unsigned NP          = 6,
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                       sys_clk,
  input wire logic                       rstn,
  input wire logic [mps_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic [NP-1:0]              pump_ready,
  input wire logic [NP-1:0]              ready_assigned,
  input wire logic [NP-1:0]              pump_cmd,
  input wire logic                       drive_run,
  input wire logic                       flying_restart,
  input wire logic                       capacity_warn,
  input wire logic                       lead_error
);
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [1:0]  arch;
  logic [2:0]  cnt;
  logic        alt;
  assign arch = ctrl_r[1:0];
  assign cnt  = ctrl_r[6:4];
  assign alt  = ctrl_r[12];
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && reg_addr == mps_pkg::REG_CTRL) begin
      ctrl_nxt = reg_wdata & 32'hFCFF_FFFF;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= mps_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_reset_clear;
    $rose(rstn) |-> pump_cmd == '0 && !drive_run && !lead_error && !flying_restart;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  property p_no_unready_start;
    !(|(pump_cmd & ~$past(pump_cmd) & ready_assigned & ~(pump_ready | $past(pump_ready)
      | $past(pump_ready, 2) | $past(pump_ready, 3) | $past(pump_ready, 4) | $past(pump_ready, 5))));
  endproperty
  a_no_unready_start: assert property (p_no_unready_start) else $error("unready pump started");
  property p_lead_first;
    pump_cmd != '0 && $past(pump_cmd) == '0 |-> $onehot(pump_cmd);
  endproperty
  a_lead_first: assert property (p_lead_first) else $error("more than one pump started first");
  property p_count_limit;
    arch == 2'h1 && ctrl_r == $past(ctrl_r, 3) |-> (pump_cmd >> cnt) == '0;
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("pump beyond count commanded");
  property p_multi_no_alt;
    arch == 2'h2 |-> !flying_restart;
  endproperty
  a_multi_no_alt: assert property (p_multi_no_alt) else $error("lead switch in multi drive mode");
  property p_fixed_lead;
    arch == 2'h1 && !alt && ctrl_r == $past(ctrl_r, 3) && pump_cmd != '0 |-> pump_cmd[0];
  endproperty
  a_fixed_lead: assert property (p_fixed_lead) else $error("pump one not lead");
  property p_lead_lost;
    arch == 2'h1 && !alt && ctrl_r[20] && ready_assigned[0] && pump_cmd[0] && !pump_ready[0]
      |-> ##[1:8] lead_error;
  endproperty
  a_lead_lost: assert property (p_lead_lost) else $error("lead loss not flagged");
  property p_read_quiet;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read data outside read slot");
endmodule : mps_sequencer_assertions

bind mps_sequencer mps_sequencer_assertions #(.NP(NP), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pump_ready(pump_ready), .ready_assigned(ready_assigned),
  .pump_cmd(pump_cmd), .drive_run(drive_run), .flying_restart(flying_restart),
  .capacity_warn(capacity_warn), .lead_error(lead_error));

// ===== test/mps_sequencer_bench.sv
// Purpose: Register-driven staging tests for the pump sequencer.
// Assumes: One second is shortened to four clocks.
// Notes:   Demand is stood in for by stage and destage requests.
module mps_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] FI = 32'h0010_0031;
  localparam logic [31:0] LI = 32'h0010_0131;
  localparam logic [31:0] ST = 32'h0100_0000;
  localparam logic [31:0] DS = 32'h0200_0000;
  logic                       sys_clk = 1'b0;
  logic                       rstn = 1'b0;
  logic [mps_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [31:0]                reg_wdata = '0;
  logic                       reg_wr = 1'b0;
  logic                       reg_rd = 1'b0;
  logic [31:0]                reg_rdata;
  logic [5:0]                 avail = 6'h3F;
  logic [5:0]                 ready_assigned = 6'h3F;
  logic [5:0]                 pump_ready;
  logic [5:0]                 pump_cmd;
  logic                       drive_run;
  logic                       lead_error;
  int                         failures = 0;
  int                         compares = 0;
  always #20 sys_clk = ~sys_clk;
  mps_pump_model #(.NP(6)) u_pumps (.avail(avail), .pump_ready(pump_ready));
  mps_sequencer #(.NP(6), .TICK_CYCLES(4)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pump_ready(pump_ready), .ready_assigned(ready_assigned),
    .pump_cmd(pump_cmd), .drive_run(drive_run), .flying_restart(), .capacity_warn(),
    .lead_error(lead_error));
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [mps_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [mps_pkg::ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 chk(what, exp, reg_rdata & m);
  endtask : rd
  // Bounded wait on pump commands (sel 0) or the lead error flag (sel 1).
  task automatic expect_sig(input int sel, input logic [31:0] exp, input string what);
    int          n;
    logic [31:0] v;
    n = 0;
    v = (sel == 0) ? {26'h0, pump_cmd} : {31'h0, lead_error};
    while (v !== exp && n < 80) begin
      @(posedge sys_clk);
      #1 n++;
      v = (sel == 0) ? {26'h0, pump_cmd} : {31'h0, lead_error};
    end
    chk(what, exp, v);
    if (v !== exp) begin
      stop_test();
    end
  endtask : expect_sig
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    chk("cmd in reset", 32'h0, {26'h0, pump_cmd});
    rd(mps_pkg::REG_STATUS, 32'h0000_7003, 32'h0, "status idle");
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0, "unmapped read");
    wr(mps_pkg::REG_WAIT, 32'h0000_0005);
    rd(mps_pkg::REG_WAIT, 32'hFFFF_FFFF, 32'h5, "wait time");
    $display("test registers done");
    wr(mps_pkg::REG_CTRL, FI);
    expect_sig(0, 32'h01, "fifo lead");
    chk("drive run", 32'h1, {31'h0, drive_run});
    wr(mps_pkg::REG_CTRL, FI | ST);
    expect_sig(0, 32'h03, "fifo stage 2");
    wr(mps_pkg::REG_CTRL, FI | ST);
    expect_sig(0, 32'h07, "fifo stage 3");
    rd(mps_pkg::REG_STATUS, 32'h0000_7700, 32'h0000_3300, "counts");
    wr(mps_pkg::REG_CTRL, FI | DS);
    expect_sig(0, 32'h05, "fifo destage");
    wr(mps_pkg::REG_CTRL, 32'h0);
    expect_sig(0, 32'h00, "stop all");
    rd(mps_pkg::REG_START_BASE, 32'h0000_FFFF, 32'h1, "pump1 starts");
    $display("test fifo done");
    wr(mps_pkg::REG_CTRL, LI | ST);
    expect_sig(0, 32'h01, "lifo lead");
    wr(mps_pkg::REG_CTRL, LI | ST);
    expect_sig(0, 32'h03, "lifo stage 2");
    wr(mps_pkg::REG_CTRL, LI | ST);
    expect_sig(0, 32'h07, "lifo stage 3");
    wr(mps_pkg::REG_CTRL, LI | DS);
    expect_sig(0, 32'h03, "lifo destage");
    wr(mps_pkg::REG_CTRL, 32'h0);
    expect_sig(0, 32'h00, "lifo stop");
    $display("test lifo done");
    wr(mps_pkg::REG_READY_DLY, 32'h0000_000A);
    wr(mps_pkg::REG_CTRL, FI);
    expect_sig(0, 32'h01, "delay lead");
    wr(mps_pkg::REG_CTRL, FI | ST);
    expect_sig(0, 32'h03, "delay stage");
    wr(mps_pkg::REG_CTRL, FI | DS);
    expect_sig(0, 32'h01, "delay destage");
    wr(mps_pkg::REG_CTRL, FI | ST);
    expect_sig(0, 32'h05, "held pump skipped");
    wr(mps_pkg::REG_CTRL, 32'h0);
    wr(mps_pkg::REG_READY_DLY, 32'h0);
    expect_sig(0, 32'h00, "delay stop");
    // The destaged pump stays held for ten ticks, so let that run out first.
    repeat (48) @(posedge sys_clk);
    $display("test ready delay done");
    avail <= 6'h3D;
    wr(mps_pkg::REG_CTRL, FI);
    expect_sig(0, 32'h01, "unready lead");
    rd(mps_pkg::REG_STATUS, 32'h0000_0700, 32'h0000_0200, "avail count");
    wr(mps_pkg::REG_CTRL, FI | ST);
    expect_sig(0, 32'h05, "unready skipped");
    wr(mps_pkg::REG_CTRL, 32'h0);
    ready_assigned <= 6'h3D;
    wr(mps_pkg::REG_CTRL, FI);
    wr(mps_pkg::REG_CTRL, FI | ST);
    expect_sig(0, 32'h03, "unassigned ready");
    wr(mps_pkg::REG_CTRL, 32'h0);
    expect_sig(0, 32'h00, "unassigned stop");
    ready_assigned <= 6'h3F;
    avail <= 6'h3F;
    $display("test availability done");
    wr(mps_pkg::REG_CTRL, FI);
    expect_sig(0, 32'h01, "error lead");
    avail <= 6'h3E;
    expect_sig(1, 32'h1, "lead error set");
    wr(mps_pkg::REG_CTRL, 32'h0);
    expect_sig(1, 32'h0, "lead error clear");
    avail <= 6'h3F;
    wr(mps_pkg::REG_CTRL, 32'h0012_1002);
    wr(mps_pkg::REG_CTRL, 32'h0112_1002);
    wr(mps_pkg::REG_CTRL, 32'h0);
    expect_sig(0, 32'h00, "multi stop");
    $display("test lead error done");
    stop_test();
  end
endmodule : mps_sequencer_bench
